// ===== src/srp_pkg.sv
`default_nettype none
package srp_pkg;
  localparam logic [7:0] GEN_ADDR = 8'hEF;
  localparam logic [7:0] CHSEL_ADDR = 8'hFC;
  localparam logic [7:0] CHCLR_ADDR = 8'hFD;
  localparam logic [7:0] PAGE_ADDR = 8'hFF;
  localparam logic [7:0] PAGE_WMASK = 8'h31;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int PAGE_CH_BIT = 0;
  localparam int PAGE_SH_LO = 4;
  localparam int SH_W = 2;
  localparam int SH_PAGES = 4;
  localparam int RSV_LO = 4;
  localparam int CHCLR_BIT = 0;
  localparam logic [6:0] SLV_BASE = 7'h18;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int CLK_NS = 4;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int MIN_QUARTER = 64;
endpackage
`default_nettype wire

// ===== src/srp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and of both open-drain ends, pull-up when nobody drives
  assign scl = (host_scl_oe ? host_scl_o : 1'b1) & (dev_scl_oe ? dev_scl_o : 1'b1);
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// ===== src/srp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module srp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [W-1:0] D_I,
  output logic [W-1:0] Q_O
);
  logic [W-1:0] meta_q;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      meta_q <= RST;
      Q_O <= RST;
    end else begin
      meta_q <= D_I;
      Q_O <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== src/srp_device.sv
// Functional notes
// RULE_01: sda falling while scl high starts
// RULE_02: sda rising while scl high stops
// RULE_03: nine clocks per byte, ninth acknowledges
// RULE_04: sender releases; receiver pulls low acknowledges
// RULE_05: write: address, register, then data bytes
// RULE_06: pointer advances after every data byte
// RULE_07: master stops right after last write
// RULE_08: read uses repeated start, address with read
// RULE_09: master leaves last read acknowledge high
// RULE_10: lines only pulled low, never driven high
// RULE_11: answer only own slave address
// RULE_12: bits are read-only, read/write, self-clearing
// RULE_13: global registers reachable on every page
// RULE_14: page bit zero selects shared page
// RULE_15: page bit one selects chosen channel
// RULE_16: each channel stores its own settings
// RULE_17: general register: reserved high, id low
// RULE_18: partial updates use read-modify-write
// RULE_19: straps sampled once, pick address 0x18-0x27
// RULE_20: load trigger low resets all registers
`timescale 1ns/1ps
`default_nettype none
module srp_device #(
  parameter int NUM_CH = 8,
  parameter int REG_DEPTH = 16,
  parameter logic [3:0] QUAD_COUNT = 4'h3 // arbitrary identification value
) (
  input wire logic LINK_CLK_I,
  input wire logic RESET_I,
  srp_if.dev BUS,
  input wire logic [1:0] STRAP_ADDR1_I,
  input wire logic [1:0] STRAP_ADDR0_I,
  input wire logic BUS_ROLE_SELECT_I,
  input wire logic LOAD_TRIG_N_I,
  output logic [6:0] SLAVE_ADDR_O,
  output logic [NUM_CH*8-1:0] CH_CTRL_O,
  output logic [7:0] SHARED_CTRL_O,
  output logic BUSY_O
);
  localparam int CH_W = $clog2(NUM_CH);
  localparam int DW = $clog2(REG_DEPTH);
  if (NUM_CH < 2 || NUM_CH > 256 || REG_DEPTH < 2 || REG_DEPTH > 239) begin : g_bad
    $error("srp_device: NUM_CH or REG_DEPTH out of range");
  end
  typedef enum logic [2:0] {
    S_IDLE, S_DEVADDR, S_REGADDR, S_WRITE, S_READ, S_SKIP
  } srp_dstate_type;
  function automatic logic is_global(input logic [7:0] a);
    return a >= srp_pkg::GEN_ADDR;
  endfunction

  logic scl_s, sda_s, role_s, load_n_s, scl_q, sda_q, scl_rise, scl_fall;
  logic start_det, stop_det, op_ok, wr_en, strap_done_q, ack_ph_q, mack_q;
  logic sda_low_q, chclr_q;
  logic [1:0] strap_cnt_q;
  logic [3:0] bit_q, gen_rsv_q;
  logic [6:0] slv_addr_q;
  logic [7:0] pin_s, shift_q, tx_q, ptr_q, chsel_q, page_q, rd_data;
  srp_dstate_type state_q;
  logic [7:0] ch_mem [NUM_CH][REG_DEPTH];
  logic [7:0] sh_mem [srp_pkg::SH_PAGES][REG_DEPTH];

  // bus lines idle high, so the synchroniser resets to the idle level
  srp_sync #(.W(8), .RST(8'hF0)) u_sync (
    .CLK_I(LINK_CLK_I),
    .RESET_I(RESET_I),
    .D_I({BUS.scl, BUS.sda, BUS_ROLE_SELECT_I, LOAD_TRIG_N_I, STRAP_ADDR1_I, STRAP_ADDR0_I}),
    .Q_O(pin_s)
  );
  assign scl_s = pin_s[7];
  assign sda_s = pin_s[6];
  assign role_s = pin_s[5];
  assign load_n_s = pin_s[4];

  always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s; // RULE_01
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s; // RULE_02
  assign op_ok = role_s & load_n_s & strap_done_q;

  // straps settle through the synchroniser before the single capture
  always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      slv_addr_q <= srp_pkg::SLV_BASE;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == srp_pkg::STRAP_WAIT) begin
        slv_addr_q <= srp_pkg::SLV_BASE + {3'h0, pin_s[3:0]}; // RULE_19
        strap_done_q <= 1'b1;
      end
    end
  end

  assign wr_en = op_ok & scl_fall & ~ack_ph_q & (bit_q == srp_pkg::ACK_BIT)
               & (state_q == S_WRITE);

  always_comb begin
    rd_data = 8'h00;
    if (is_global(ptr_q)) begin // RULE_13
      case (ptr_q)
        srp_pkg::GEN_ADDR: rd_data = {gen_rsv_q, QUAD_COUNT}; // RULE_17
        srp_pkg::CHSEL_ADDR: rd_data = chsel_q;
        srp_pkg::CHCLR_ADDR: rd_data = {7'h00, chclr_q};
        srp_pkg::PAGE_ADDR: rd_data = page_q;
        default: rd_data = 8'h00;
      endcase
    end else if (int'(ptr_q) < REG_DEPTH) begin
      if (!page_q[srp_pkg::PAGE_CH_BIT]) begin
        rd_data = sh_mem[page_q[srp_pkg::PAGE_SH_LO +: srp_pkg::SH_W]][ptr_q[DW-1:0]]; // RULE_14
      end else if (int'(chsel_q) < NUM_CH) begin
        rd_data = ch_mem[chsel_q[CH_W-1:0]][ptr_q[DW-1:0]]; // RULE_15
      end
    end
  end

  always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q <= S_IDLE;
      bit_q <= 4'h0;
      ack_ph_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'hFF;
      ptr_q <= 8'h00;
      mack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (!op_ok) begin
      state_q <= S_IDLE;
      ack_ph_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_det) begin // RULE_08
      state_q <= S_DEVADDR;
      bit_q <= 4'h0;
      ack_ph_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (stop_det) begin // RULE_07
      state_q <= S_IDLE;
      ack_ph_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (state_q != S_IDLE && state_q != S_SKIP) begin
      if (scl_rise) begin
        if (!ack_ph_q) begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_q <= bit_q + 4'h1; // RULE_03
        end else if (state_q == S_READ) begin
          mack_q <= ~sda_s; // RULE_09
        end
      end else if (scl_fall) begin
        if (ack_ph_q) begin
          ack_ph_q <= 1'b0;
          bit_q <= 4'h0;
          sda_low_q <= 1'b0;
          if (state_q == S_READ) begin
            if (mack_q) begin
              tx_q <= {rd_data[6:0], 1'b1};
              sda_low_q <= ~rd_data[7];
              ptr_q <= ptr_q + 8'h01;
            end else begin
              state_q <= S_SKIP; // RULE_09
            end
          end
        end else if (bit_q == srp_pkg::ACK_BIT) begin
          ack_ph_q <= 1'b1;
          case (state_q)
            S_DEVADDR: begin
              if (shift_q[7:1] == slv_addr_q) begin // RULE_11
                sda_low_q <= 1'b1; // RULE_04
                if (shift_q[0]) begin
                  state_q <= S_READ; // RULE_08
                  mack_q <= 1'b1;
                end else begin
                  state_q <= S_REGADDR;
                end
              end else begin
                state_q <= S_SKIP;
              end
            end
            S_REGADDR: begin
              ptr_q <= shift_q;
              sda_low_q <= 1'b1;
              state_q <= S_WRITE;
            end
            S_WRITE: begin
              ptr_q <= ptr_q + 8'h01; // RULE_06
              sda_low_q <= 1'b1;
            end
            default: sda_low_q <= 1'b0; // RULE_04
          endcase
        end else if (state_q == S_READ) begin
          sda_low_q <= ~tx_q[7];
          tx_q <= {tx_q[6:0], 1'b1};
        end
      end
    end
  end

  // a self-clearing channel wipe shares the write port, so a write in the
  // same cycle lands after the wipe and survives
  always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int r = 0; r < REG_DEPTH; r++) ch_mem[c][r] <= srp_pkg::REG_RST;
      end
      for (int p = 0; p < srp_pkg::SH_PAGES; p++) begin
        for (int r = 0; r < REG_DEPTH; r++) sh_mem[p][r] <= srp_pkg::REG_RST;
      end
      gen_rsv_q <= 4'h0;
      chsel_q <= 8'h00;
      page_q <= 8'h00;
      chclr_q <= 1'b0;
    end else if (!load_n_s) begin // RULE_20
      for (int c = 0; c < NUM_CH; c++) begin
        for (int r = 0; r < REG_DEPTH; r++) ch_mem[c][r] <= srp_pkg::REG_RST;
      end
      for (int p = 0; p < srp_pkg::SH_PAGES; p++) begin
        for (int r = 0; r < REG_DEPTH; r++) sh_mem[p][r] <= srp_pkg::REG_RST;
      end
      gen_rsv_q <= 4'h0;
      chsel_q <= 8'h00;
      page_q <= 8'h00;
      chclr_q <= 1'b0;
    end else begin
      if (chclr_q) begin
        chclr_q <= 1'b0; // RULE_12
        if (int'(chsel_q) < NUM_CH) begin
          for (int r = 0; r < REG_DEPTH; r++) ch_mem[chsel_q[CH_W-1:0]][r] <= srp_pkg::REG_RST;
        end
      end
      if (wr_en) begin
        if (is_global(ptr_q)) begin // RULE_13
          case (ptr_q)
            srp_pkg::GEN_ADDR: gen_rsv_q <= shift_q[7:srp_pkg::RSV_LO]; // RULE_17
            srp_pkg::CHSEL_ADDR: chsel_q <= shift_q;
            srp_pkg::CHCLR_ADDR: chclr_q <= shift_q[srp_pkg::CHCLR_BIT]; // RULE_12
            srp_pkg::PAGE_ADDR: page_q <= shift_q & srp_pkg::PAGE_WMASK;
            default: ;
          endcase
        end else if (int'(ptr_q) < REG_DEPTH) begin
          if (!page_q[srp_pkg::PAGE_CH_BIT]) begin
            sh_mem[page_q[srp_pkg::PAGE_SH_LO +: srp_pkg::SH_W]][ptr_q[DW-1:0]] <= shift_q;
          end else if (int'(chsel_q) < NUM_CH) begin
            ch_mem[chsel_q[CH_W-1:0]][ptr_q[DW-1:0]] <= shift_q; // RULE_16
          end
        end
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign CH_CTRL_O[c*8 +: 8] = ch_mem[c][0]; // RULE_16
  end
  assign SHARED_CTRL_O = sh_mem[0][0];
  assign SLAVE_ADDR_O = slv_addr_q;
  assign BUSY_O = (state_q != S_IDLE);
  // no clock stretching: the clock line is never pulled
  assign BUS.dev_scl_o = 1'b0;
  assign BUS.dev_scl_oe = 1'b0; // RULE_10
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe = sda_low_q; // RULE_10
endmodule
`default_nettype wire

// ===== src/srp_host.sv
`timescale 1ns/1ps
`default_nettype none
module srp_host #(
  parameter int QUARTER = srp_pkg::QUARTER_CYC
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  srp_if.host BUS,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic CMD_READ_I,
  input wire logic [6:0] CMD_DEV_I,
  input wire logic [7:0] CMD_REG_I,
  input wire logic [3:0] CMD_LEN_I,
  input wire logic [7:0] WDATA_I,
  output logic WDATA_TAKE_O,
  output logic [7:0] RDATA_O,
  output logic RDATA_VALID_O,
  output logic DONE_O,
  output logic NACK_O
);
  if (QUARTER < srp_pkg::MIN_QUARTER || QUARTER > 65535) begin : g_bad
    $error("srp_host: QUARTER out of range");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} srp_hsym_type;
  typedef enum logic [2:0] {ST_DEVW, ST_REG, ST_WDATA, ST_DEVR, ST_RDATA} srp_hstage_type;

  srp_hsym_type sym_q;
  srp_hstage_type stage_q;
  logic sda_s;
  logic [15:0] div_q;
  logic tick;
  logic [1:0] qph_q;
  logic [3:0] bit_q;
  logic [7:0] byte_q;
  logic [7:0] rx_q;
  logic ack_in_q;
  logic rd_mode_q;
  logic read_q;
  logic [6:0] dev_q;
  logic [7:0] reg_q;
  logic [3:0] remain_q;
  logic scl_low_q;
  logic sda_low_q;

  srp_sync #(.W(1), .RST(1'b1)) u_sync (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .D_I(BUS.sda),
    .Q_O(sda_s)
  );

  // the bus clock is a divided copy of CLK_I, four quarters per bit
  assign tick = (div_q == 16'(QUARTER - 1));
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      div_q <= 16'h0000;
    end else if (sym_q == H_IDLE || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sym_q <= H_IDLE;
      stage_q <= ST_DEVW;
      qph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 8'h00;
      rx_q <= 8'h00;
      ack_in_q <= 1'b1;
      rd_mode_q <= 1'b0;
      read_q <= 1'b0;
      dev_q <= 7'h00;
      reg_q <= 8'h00;
      remain_q <= 4'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      WDATA_TAKE_O <= 1'b0;
      RDATA_O <= 8'h00;
      RDATA_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      NACK_O <= 1'b0;
    end else begin
      WDATA_TAKE_O <= 1'b0;
      RDATA_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      if (sym_q == H_IDLE) begin
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        qph_q <= 2'h0;
        if (CMD_VALID_I) begin
          sym_q <= H_START;
          stage_q <= ST_DEVW;
          read_q <= CMD_READ_I;
          dev_q <= CMD_DEV_I;
          reg_q <= CMD_REG_I;
          remain_q <= CMD_LEN_I;
          rd_mode_q <= 1'b0;
          NACK_O <= 1'b0;
        end
      end else if (tick) begin
        qph_q <= qph_q + 2'h1;
        case (sym_q)
          H_START: begin
            case (qph_q)
              2'h0: begin
                scl_low_q <= 1'b1;
                sda_low_q <= 1'b0;
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1; // RULE_01
              default: begin
                scl_low_q <= 1'b1;
                sym_q <= H_BYTE;
                bit_q <= 4'h0;
                byte_q <= {dev_q, stage_q == ST_DEVR}; // RULE_05 RULE_08
              end
            endcase
          end
          H_STOP: begin
            case (qph_q)
              2'h0: begin
                scl_low_q <= 1'b1;
                sda_low_q <= 1'b1;
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0; // RULE_02
              default: begin
                sym_q <= H_IDLE;
                DONE_O <= 1'b1;
              end
            endcase
          end
          H_BYTE: begin
            case (qph_q)
              2'h0: begin
                scl_low_q <= 1'b1;
                if (bit_q == srp_pkg::ACK_BIT) begin
                  sda_low_q <= rd_mode_q & (remain_q != 4'h0); // RULE_04 RULE_09
                end else begin
                  sda_low_q <= ~rd_mode_q & ~byte_q[7]; // RULE_10
                end
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2: begin
                if (bit_q == srp_pkg::ACK_BIT) begin
                  ack_in_q <= sda_s;
                end else begin
                  rx_q <= {rx_q[6:0], sda_s};
                end
              end
              default: begin
                scl_low_q <= 1'b1;
                if (bit_q != srp_pkg::ACK_BIT) begin
                  bit_q <= bit_q + 4'h1; // RULE_03
                  byte_q <= {byte_q[6:0], 1'b1};
                end else begin
                  bit_q <= 4'h0;
                  if (rd_mode_q) begin
                    RDATA_O <= rx_q;
                    RDATA_VALID_O <= 1'b1;
                    if (remain_q == 4'h0) begin
                      sym_q <= H_STOP;
                    end else begin
                      remain_q <= remain_q - 4'h1;
                    end
                  end else if (ack_in_q) begin
                    NACK_O <= 1'b1;
                    sym_q <= H_STOP;
                  end else begin
                    case (stage_q)
                      ST_DEVW: begin
                        stage_q <= ST_REG;
                        byte_q <= reg_q; // RULE_05
                      end
                      ST_REG, ST_WDATA: begin
                        if (stage_q == ST_REG && read_q) begin
                          stage_q <= ST_DEVR;
                          sym_q <= H_START; // RULE_08
                        end else if (remain_q == 4'h0) begin
                          sym_q <= H_STOP; // RULE_07
                        end else begin
                          // whole bytes only; field updates are the caller's
                          // read-modify-write
                          stage_q <= ST_WDATA;
                          byte_q <= WDATA_I; // RULE_18
                          WDATA_TAKE_O <= 1'b1;
                          remain_q <= remain_q - 4'h1;
                        end
                      end
                      ST_DEVR: begin
                        stage_q <= ST_RDATA;
                        rd_mode_q <= 1'b1;
                        remain_q <= (remain_q == 4'h0) ? 4'h0 : remain_q - 4'h1;
                      end
                      default: sym_q <= H_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          default: sym_q <= H_IDLE;
        endcase
      end
    end
  end

  assign CMD_READY_O = (sym_q == H_IDLE);
  assign BUS.host_scl_o = 1'b0;
  assign BUS.host_scl_oe = scl_low_q;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ===== bench/srp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module srp_monitor #(
  parameter int QUARTER = 64
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic busy_q;
  logic [15:0] hi_cnt_q;
  logic [15:0] lo_cnt_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      busy_q <= 1'h0;
    end else if (scl && scl_q && sda_q && !sda) begin
      busy_q <= 1'h1;
    end else if (scl && scl_q && !sda_q && sda) begin
      busy_q <= 1'h0;
    end
  end
  // counters saturate so a long idle high cannot wrap into a short one
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hi_cnt_q <= 16'h0;
      lo_cnt_q <= 16'h0;
    end else begin
      hi_cnt_q <= !scl ? 16'h0 : (hi_cnt_q == 16'hFFFF ? hi_cnt_q : hi_cnt_q + 16'h1);
      lo_cnt_q <= scl ? 16'h0 : (lo_cnt_q == 16'hFFFF ? lo_cnt_q : lo_cnt_q + 16'h1);
    end
  end
  chk_dev_sda_od: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  chk_dev_scl_od: assert property (!dev_scl_oe || !dev_scl_o)
    else $error("device drives clock high");
  chk_host_od_low: assert property ((host_scl_oe |-> !host_scl_o) and (host_sda_oe |-> !host_sda_o))
    else $error("host drives a line high");
  chk_start_by_host: assert property (start_s |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by host");
  chk_stop_release: assert property (stop_s |-> (!host_scl_oe && !dev_sda_oe) [*8])
    else $error("line held after stop");
  chk_sda_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved data while clock high");
  chk_ack_lag: assert property ($changed(dev_sda_oe) |-> !scl && lo_cnt_q <= QUARTER + QUARTER / 2)
    else $error("device data change late or outside clock low");
  chk_scl_high_len: assert property ($fell(scl) && busy_q |-> hi_cnt_q >= QUARTER)
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// ===== bench/test_smbus_slave_register_pager.sv
`timescale 1ns/1ps
`default_nettype none
module test_smbus_slave_register_pager;
  typedef struct packed {
    logic rd;
    logic [7:0] rg;
    logic [3:0] len;
    logic [31:0] wd;
    logic [31:0] ex;
  } srp_row_type;
  localparam int QUARTER = 64;
  logic clk, link_clk, rst, cmd_valid, cmd_ready, cmd_read, take, rvalid, done, nack, busy, load_n;
  logic [6:0] cmd_dev, slave_addr;
  logic [7:0] cmd_reg, wdata, rdata, shared_ctrl;
  logic [3:0] cmd_len;
  logic [63:0] ch_ctrl;
  logic [31:0] rv;
  logic nk;
  int n_fail = 0;
  int compares = 0;
  // channel mode on channel 2, then back to shared page 0
  srp_row_type rows [7] = '{
    '{1'h0, 8'hEF, 4'h1, 32'hFF000000, 32'h0},
    '{1'h1, 8'hEF, 4'h1, 32'h0, 32'h000000F3},
    '{1'h0, 8'hFC, 4'h4, 32'h02000001, 32'h0},
    '{1'h0, 8'h00, 4'h2, 32'hA53C0000, 32'h0},
    '{1'h1, 8'h00, 4'h2, 32'h0, 32'h0000A53C},
    '{1'h0, 8'hFF, 4'h1, 32'h0, 32'h0},
    '{1'h0, 8'h00, 4'h1, 32'h77000000, 32'h0}};
  srp_if i_srp_if();
  srp_host #(.QUARTER(QUARTER)) i_srp_host (.CLK_I(clk), .RESET_I(rst), .BUS(i_srp_if),
    .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_READ_I(cmd_read),
    .CMD_DEV_I(cmd_dev), .CMD_REG_I(cmd_reg), .CMD_LEN_I(cmd_len), .WDATA_I(wdata),
    .WDATA_TAKE_O(take), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .DONE_O(done),
    .NACK_O(nack));
  srp_device i_srp_device (.LINK_CLK_I(link_clk), .RESET_I(rst), .BUS(i_srp_if),
    .STRAP_ADDR1_I(2'h1), .STRAP_ADDR0_I(2'h2), .BUS_ROLE_SELECT_I(1'h1),
    .LOAD_TRIG_N_I(load_n), .SLAVE_ADDR_O(slave_addr), .CH_CTRL_O(ch_ctrl),
    .SHARED_CTRL_O(shared_ctrl), .BUSY_O(busy));
  srp_monitor #(.QUARTER(QUARTER)) i_srp_monitor (.CLK_I(clk), .RESET_I(rst),
    .host_scl_o(i_srp_if.host_scl_o), .host_scl_oe(i_srp_if.host_scl_oe),
    .host_sda_o(i_srp_if.host_sda_o), .host_sda_oe(i_srp_if.host_sda_oe),
    .dev_scl_o(i_srp_if.dev_scl_o), .dev_scl_oe(i_srp_if.dev_scl_oe),
    .dev_sda_o(i_srp_if.dev_sda_o), .dev_sda_oe(i_srp_if.dev_sda_oe),
    .scl(i_srp_if.scl), .sda(i_srp_if.sda));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // link clock phase deliberately unrelated to the host clock
  initial begin
    link_clk = 1'h0;
    #7.3;
    forever #32 link_clk = ~link_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_cmd(input logic rd, input logic [6:0] dv, input logic [7:0] rg,
    input logic [3:0] ln, input logic [31:0] wd, output logic [31:0] rd_v, output logic nk_v);
    logic [31:0] w;
    w = wd;
    rd_v = 32'h0;
    @(posedge clk);
    #1;
    cmd_valid = 1'h1;
    cmd_read = rd;
    cmd_dev = dv;
    cmd_reg = rg;
    cmd_len = ln;
    wdata = w[31:24];
    @(posedge clk);
    #1;
    cmd_valid = 1'h0;
    chk(64'(cmd_ready), 64'h0, "ready in command");
    // bounded wait; the watchdog reports a hang
    for (int k = 0; k < 40000; k++) begin
      if (take === 1'h1) begin
        chk(64'(busy), 64'h1, "busy in frame");
        w = w << 8;
        wdata = w[31:24];
      end
      if (rvalid === 1'h1) rd_v = {rd_v[23:0], rdata};
      if (done === 1'h1) break;
      @(posedge clk);
      #1;
    end
    nk_v = nack;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    rst = 1'h1;
    load_n = 1'h1;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_dev = 7'h0;
    cmd_reg = 8'h0;
    cmd_len = 4'h0;
    wdata = 8'h0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (8) @(posedge link_clk);
    chk(64'(slave_addr), 64'h1E, "slave address");
    chk(ch_ctrl, 64'h0, "channel reset");
    foreach (rows[i]) begin
      do_cmd(rows[i].rd, 7'h1E, rows[i].rg, rows[i].len, rows[i].wd, rv, nk);
      chk(64'(nk), 64'h0, "ack");
      chk(64'(cmd_ready), 64'h1, "ready after stop");
      if (rows[i].rd) chk(64'(rv), 64'(rows[i].ex), "read data");
    end
    chk(ch_ctrl, 64'h0000000000A50000, "channel regs");
    chk(64'(shared_ctrl), 64'h77, "shared reg");
    chk(64'(busy), 64'h0, "busy idle");
    // another device's address must be ignored
    do_cmd(1'h0, 7'h20, 8'h00, 4'h1, 32'h11000000, rv, nk);
    chk(64'(nk), 64'h1, "foreign nack");
    chk(64'(shared_ctrl), 64'h77, "foreign write");
    do_cmd(1'h0, 7'h1E, 8'hFD, 4'h1, 32'h01000000, rv, nk);
    chk(ch_ctrl, 64'h0, "self clear");
    load_n = 1'h0;
    repeat (6) @(posedge link_clk);
    #1;
    chk(64'(shared_ctrl), 64'h0, "load reset");
    load_n = 1'h1;
    give_verdict();
  end
endmodule
`default_nettype wire
